// File: include/adp_pkg.sv
/*
 * adp_pkg: constants and carrier types of the audio descriptor parser.
 * Assumes a single clock domain; included before every rtl file.
 */
package adp_pkg;

    localparam logic [7:0] TAG_AUDIO = 8'h6A;
    localparam logic [7:0] TAG_LANG = 8'h0A;
    localparam logic [7:0] STREAM_TYPE_PRIV = 8'h06;
    localparam logic [7:0] PES_PRIV_ONE = 8'hBD;
    localparam logic [7:0] CONTENT_AUDIO = 8'h04;
    localparam logic [4:0] VERSION_CURRENT = 5'h08;
    localparam logic [2:0] MAIN_MAX = 3'h7;

    // presence flag positions inside the flag byte
    localparam int FLG_KIND = 7;
    localparam int FLG_VERSION = 6;
    localparam int FLG_MAIN = 5;
    localparam int FLG_ASSOC = 4;

    // fields inside the audio kind code
    localparam int KIND_RESERVED = 7;
    localparam int KIND_FULL = 6;
    localparam int KIND_SVC_LSB = 3;
    localparam int KIND_CHAN_LSB = 0;

    localparam logic [1:0] LANG_BYTES = 2'h3;
    localparam logic [7:0] LEN_LAST = 8'h01;

    // buffer sizes in bytes
    localparam logic [15:0] MULTIPLEX_SLACK_BYTES = 16'h02E0;
    localparam logic [15:0] PADDING_BYTES = 16'h0040;
    localparam logic [15:0] OTHER_AUDIO_BUFFER = 16'h0E00;

    localparam int FIFO_DEPTH = 8;
    localparam int BEAT_W = 9;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } adp_beat_t;

    typedef struct packed {
        logic found;
        logic audio_kind_present;
        logic version_present;
        logic main_present;
        logic assoc_present;
        logic [7:0] audio_kind_code;
        logic kind_reserved;
        logic full_service;
        logic [2:0] service_type;
        logic [2:0] channel_cfg;
        logic [4:0] coding_version;
        logic version_hi_nonzero;
        logic version_is_current;
        logic [2:0] main_service;
        logic main_out_of_range;
        logic [7:0] assoc_mask;
        logic [12:0] pid;
    } adp_fields_t;

    typedef enum logic [2:0] {
        S_TAG = 3'h0,
        S_LEN = 3'h1,
        S_FLAGS = 3'h2,
        S_OPT = 3'h3,
        S_SKIP = 3'h4,
        S_LANG = 3'h5
    } adp_state_t;

endpackage

// File: rtl/adp_fifo.sv
/*
 * adp_fifo: small byte FIFO with valid/ready on both sides.
 * Assumes producer and consumer share clk_sys_i.
 */
`timescale 1ns/100ps
`default_nettype none

module adp_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
        logic in_ready;
        logic out_valid;
    } adp_fifo_st_t;

    adp_fifo_st_t st_reg;
    adp_fifo_st_t st_next;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        st_next = st_reg;
        push = in_valid_i & st_reg.in_ready;
        pop = st_reg.out_valid & out_ready_i;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = ptr_inc(st_reg.wr);
        end
        if (pop) begin
            st_next.rd = ptr_inc(st_reg.rd);
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        // flags from the next count keep both handshakes registered
        st_next.in_ready = (st_next.cnt != CNT_FULL);
        st_next.out_valid = (st_next.cnt != '0);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.in_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready_o = st_reg.in_ready;
    assign out_valid_o = st_reg.out_valid;
    assign out_data_o = st_reg.mem[st_reg.rd];

endmodule // adp_fifo

`default_nettype wire

// File: rtl/adp_parser.sv
/*
 * adp_parser: walks a descriptor loop byte by byte, extracts the
 * compressed-audio service descriptor and the language descriptor,
 * flags stream type, PES stream number and content, and sums the buffer size.
 * Assumes the byte source runs on clk_sys_i and marks each tag byte
 * that starts a new descriptor loop with first.
 */
// Overview of operation
// - tag byte 6A alone marks an audio service descriptor.
// - length byte counts payload bytes; exactly that many are consumed.
// - payload holds at least the flag byte; zero length is malformed.
// - flag byte bits 7..4 announce kind, version, main number, mask.
// - optional bytes follow in that fixed order, only when flagged.
// - audio kind code is passed on unchanged as component type.
// - version byte upper three bits zero, lower five give version 8.
// - main service number is 0 to 7, unique per main service.
// - mask bit n set means playable with main service n.
// - bytes left after optional fields are skipped uninterpreted.
// - audio stream announced with stream type 06 (private PES data).
// - PES packets carry stream number BD, private stream one.
// - streams sharing stream number are told apart by PID only.
// - access unit buffer always sized for the highest system bit rate.
// - other audio uses a fixed 3584 byte main buffer.
// - component type table applies only when stream content is 04.
// - language descriptor yields a 24-bit code from three bytes.
// - kind bit 7 reserved; else full flag, service type, channels.
`timescale 1ns/100ps
`default_nettype none

module adp_parser #(
    parameter int FIFO_DEPTH = adp_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire adp_pkg::adp_beat_t in_beat_i,
    output logic in_ready_o,
    input wire logic hold_i,
    input wire logic [7:0] pmt_stream_type_i,
    input wire logic [7:0] pes_stream_number_i,
    input wire logic [12:0] pid_i,
    input wire logic [7:0] comp_stream_content_i,
    input wire logic [15:0] access_unit_buffer_i,
    output adp_pkg::adp_fields_t fields_o,
    output logic done_o,
    output logic malformed_o,
    output logic stream_type_ok_o,
    output logic pes_id_ok_o,
    output logic comp_type_applies_o,
    output logic [15:0] main_audio_buffer_total_o,
    output logic lang_valid_o,
    output logic [23:0] lang_code_o
);

    typedef enum logic [1:0] {
        K_OTHER = 2'h0,
        K_AUDIO = 2'h1,
        K_LANG = 2'h2
    } adp_kind_t;

    typedef struct packed {
        adp_pkg::adp_state_t state;
        adp_kind_t kind;
        logic [7:0] rem;
        logic [3:0] pend;
        logic [1:0] lang_cnt;
        adp_pkg::adp_fields_t res;
        logic done;
        logic malformed;
        logic stream_type_ok;
        logic pes_id_ok;
        logic comp_applies;
        logic [15:0] buf_total;
        logic lang_valid;
        logic [23:0] lang_code;
    } adp_st_t;

    adp_st_t st_reg;
    adp_st_t st_next;

    logic fifo_valid;
    adp_pkg::adp_beat_t fifo_beat;
    logic take;
    logic last;
    logic [7:0] b;
    logic [3:0] left;

    // pending bits left once the highest set one is cleared by the msb-first pick
    function automatic logic [3:0] drop_top(input logic [3:0] p);
        logic [3:0] r;
        r = p;
        if (p[3]) begin
            r[3] = 1'b0;
        end else if (p[2]) begin
            r[2] = 1'b0;
        end else if (p[1]) begin
            r[1] = 1'b0;
        end else begin
            r[0] = 1'b0;
        end
        drop_top = r;
    endfunction

    adp_fifo #(
        .W(adp_pkg::BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(in_valid_i),
        .in_data_i(in_beat_i),
        .in_ready_o(in_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_beat),
        .out_ready_i(!hold_i)
    );

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        take = fifo_valid & !hold_i;
        b = fifo_beat.data;
        last = (st_reg.rem == adp_pkg::LEN_LAST);
        left = 4'h0;

        st_next.stream_type_ok =
            (pmt_stream_type_i == adp_pkg::STREAM_TYPE_PRIV);
        st_next.pes_id_ok =
            (pes_stream_number_i == adp_pkg::PES_PRIV_ONE);
        st_next.comp_applies =
            (comp_stream_content_i == adp_pkg::CONTENT_AUDIO);

        // access unit term arrives already sized for the top bit rate
        if (st_reg.res.found) begin
            st_next.buf_total = adp_pkg::MULTIPLEX_SLACK_BYTES
                + adp_pkg::PADDING_BYTES
                + access_unit_buffer_i;
        end else begin
            st_next.buf_total = adp_pkg::OTHER_AUDIO_BUFFER;
        end

        if (take) begin
            // a first beat resynchronises; a cut descriptor is dropped
            if (fifo_beat.first || st_reg.state == adp_pkg::S_TAG) begin
                st_next.state = adp_pkg::S_LEN;
                if (b == adp_pkg::TAG_AUDIO) begin
                    st_next.kind = K_AUDIO;
                    st_next.res = '0;
                    st_next.malformed = 1'b0;
                end else if (b == adp_pkg::TAG_LANG) begin
                    st_next.kind = K_LANG;
                end else begin
                    st_next.kind = K_OTHER;
                end
            end else begin
                case (st_reg.state)
                    adp_pkg::S_LEN: begin
                        st_next.rem = b;
                        st_next.lang_cnt = 2'h0;
                        if (b == 8'h00) begin
                            st_next.state = adp_pkg::S_TAG;
                            if (st_reg.kind == K_AUDIO) begin
                                st_next.malformed = 1'b1;
                                st_next.done = 1'b1;
                                st_next.res.found = 1'b1;
                                st_next.res.pid = pid_i;
                            end
                        end else if (st_reg.kind == K_AUDIO) begin
                            st_next.state = adp_pkg::S_FLAGS;
                        end else if (st_reg.kind == K_LANG) begin
                            st_next.state = adp_pkg::S_LANG;
                        end else begin
                            st_next.state = adp_pkg::S_SKIP;
                        end
                    end
                    adp_pkg::S_FLAGS: begin
                        // low nibble is reserved and not looked at
                        st_next.pend = {b[adp_pkg::FLG_KIND],
                                        b[adp_pkg::FLG_VERSION],
                                        b[adp_pkg::FLG_MAIN],
                                        b[adp_pkg::FLG_ASSOC]};
                        st_next.rem = st_reg.rem - 1'b1;
                        if (last) begin
                            st_next.state = adp_pkg::S_TAG;
                            st_next.done = 1'b1;
                            st_next.res.found = 1'b1;
                            st_next.res.pid = pid_i;
                            st_next.malformed = (st_next.pend != 4'h0);
                        end else if (st_next.pend == 4'h0) begin
                            st_next.state = adp_pkg::S_SKIP;
                        end else begin
                            st_next.state = adp_pkg::S_OPT;
                        end
                    end
                    adp_pkg::S_OPT: begin
                        left = drop_top(st_reg.pend);
                        st_next.pend = left;
                        st_next.rem = st_reg.rem - 1'b1;
                        if (st_reg.pend[3]) begin
                            st_next.res.audio_kind_present = 1'b1;
                            st_next.res.audio_kind_code = b;
                            st_next.res.kind_reserved =
                                b[adp_pkg::KIND_RESERVED];
                            st_next.res.full_service =
                                b[adp_pkg::KIND_FULL];
                            st_next.res.service_type =
                                b[adp_pkg::KIND_SVC_LSB +: 3];
                            st_next.res.channel_cfg =
                                b[adp_pkg::KIND_CHAN_LSB +: 3];
                        end else if (st_reg.pend[2]) begin
                            st_next.res.version_present = 1'b1;
                            st_next.res.coding_version = b[4:0];
                            st_next.res.version_hi_nonzero = (b[7:5] != 3'h0);
                            st_next.res.version_is_current =
                                (b[7:5] == 3'h0)
                                && (b[4:0] == adp_pkg::VERSION_CURRENT);
                        end else if (st_reg.pend[1]) begin
                            st_next.res.main_present = 1'b1;
                            st_next.res.main_service = b[2:0];
                            st_next.res.main_out_of_range =
                                (b > {5'h00, adp_pkg::MAIN_MAX});
                        end else begin
                            st_next.res.assoc_present = 1'b1;
                            st_next.res.assoc_mask = b;
                        end
                        if (last) begin
                            st_next.state = adp_pkg::S_TAG;
                            st_next.done = 1'b1;
                            st_next.res.found = 1'b1;
                            st_next.res.pid = pid_i;
                            st_next.malformed = (left != 4'h0);
                        end else if (left == 4'h0) begin
                            st_next.state = adp_pkg::S_SKIP;
                        end
                    end
                    adp_pkg::S_SKIP: begin
                        st_next.rem = st_reg.rem - 1'b1;
                        if (last) begin
                            st_next.state = adp_pkg::S_TAG;
                            if (st_reg.kind == K_AUDIO) begin
                                st_next.done = 1'b1;
                                st_next.res.found = 1'b1;
                                st_next.res.pid = pid_i;
                            end
                        end
                    end
                    adp_pkg::S_LANG: begin
                        st_next.rem = st_reg.rem - 1'b1;
                        if (st_reg.lang_cnt != adp_pkg::LANG_BYTES) begin
                            st_next.lang_code =
                                {st_reg.lang_code[15:0], b};
                            st_next.lang_cnt = st_reg.lang_cnt + 1'b1;
                            if (st_next.lang_cnt == adp_pkg::LANG_BYTES) begin
                                st_next.lang_valid = 1'b1;
                            end else begin
                                st_next.lang_valid = 1'b0;
                            end
                        end
                        if (last) begin
                            st_next.state = adp_pkg::S_TAG;
                        end
                    end
                    default: begin
                        st_next.state = adp_pkg::S_TAG;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.state <= adp_pkg::S_TAG;
            st_reg.buf_total <= adp_pkg::OTHER_AUDIO_BUFFER;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fields_o = st_reg.res;
    assign done_o = st_reg.done;
    assign malformed_o = st_reg.malformed;
    assign stream_type_ok_o = st_reg.stream_type_ok;
    assign pes_id_ok_o = st_reg.pes_id_ok;
    assign comp_type_applies_o = st_reg.comp_applies;
    assign main_audio_buffer_total_o = st_reg.buf_total;
    assign lang_valid_o = st_reg.lang_valid;
    assign lang_code_o = st_reg.lang_code;

endmodule // adp_parser

`default_nettype wire

// File: tb/adp_demux_model.sv
/*
 * adp_demux_model: section byte source standing in for the demultiplexer.
 * Assumes the bench queues bytes through put and shares clk_sys_i.
 */
`timescale 1ns/100ps
`default_nettype none

module adp_demux_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic ready_i,
    output logic valid_o,
    output adp_pkg::adp_beat_t beat_o,
    output logic idle_o
);
    adp_pkg::adp_beat_t q [$];

    task automatic put(input logic first, input logic [7:0] data);
        q.push_back({first, data});
    endtask

    // offer held until taken; slow_i only delays the next offer
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            beat_o <= '0;
            idle_o <= 1'b1;
        end else begin
            // queue state sampled per edge, one cycle behind
            idle_o <= (q.size() == 0) && !valid_o;
            if (!valid_o || ready_i) begin
                if (q.size() > 0 && !slow_i) begin
                    valid_o <= 1'b1;
                    beat_o <= q.pop_front();
                end else begin
                    valid_o <= 1'b0;
                    // released lines invert on each idle edge, so the last byte comes back every other cycle
                    beat_o <= ~beat_o;
                end
            end
        end
    end
endmodule // adp_demux_model

`default_nettype wire

// File: tb/adp_parser_properties.sv
/*
 * adp_parser_checker: port-level properties of adp_parser, bound below.
 * Assumes one clock domain and rst_i asynchronous, active high.
 */
`timescale 1ns/100ps
`default_nettype none

module adp_parser_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] pmt_stream_type_i,
    input wire logic [7:0] pes_stream_number_i,
    input wire logic [7:0] comp_stream_content_i,
    input wire logic [15:0] access_unit_buffer_i,
    input wire adp_pkg::adp_fields_t fields_o,
    input wire logic done_o,
    input wire logic malformed_o,
    input wire logic stream_type_ok_o,
    input wire logic pes_id_ok_o,
    input wire logic comp_type_applies_o,
    input wire logic [15:0] main_audio_buffer_total_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_stype_flag: assert property (
        !$past(rst_i) |-> stream_type_ok_o == ($past(pmt_stream_type_i) == 8'h06))
        else $error("stream type flag wrong");
    chk_pes_flag: assert property (
        !$past(rst_i) |-> pes_id_ok_o == ($past(pes_stream_number_i) == 8'hBD))
        else $error("pes stream number flag wrong");
    chk_content_flag: assert property (
        !$past(rst_i) |-> comp_type_applies_o == ($past(comp_stream_content_i) == 8'h04))
        else $error("component content flag wrong");
    chk_done_pulse: assert property (
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_done_found: assert property (
        done_o |-> fields_o.found)
        else $error("done without found");
    chk_kind_split: assert property (
        done_o && fields_o.audio_kind_present |-> {fields_o.kind_reserved,
        fields_o.full_service, fields_o.service_type, fields_o.channel_cfg}
        == fields_o.audio_kind_code)
        else $error("kind subfields disagree with code");
    chk_version_flag: assert property (
        done_o && fields_o.version_present |-> fields_o.version_is_current
        == (!fields_o.version_hi_nonzero && fields_o.coding_version == 5'h08))
        else $error("version current flag wrong");
    chk_buf_idle: assert property (
        !$past(fields_o.found) |-> main_audio_buffer_total_o == 16'h0E00)
        else $error("buffer total not default");
    chk_buf_sum: assert property (
        $past(fields_o.found)
        |-> main_audio_buffer_total_o == 16'h0320 + $past(access_unit_buffer_i))
        else $error("buffer total sum wrong");
    chk_bad_done: assert property (
        $rose(malformed_o) |-> done_o)
        else $error("malformed rose without done");
endmodule // adp_parser_checker

bind adp_parser adp_parser_checker adp_parser_checker_i (
    .clk_sys_i,
    .rst_i,
    .pmt_stream_type_i,
    .pes_stream_number_i,
    .comp_stream_content_i,
    .access_unit_buffer_i,
    .fields_o,
    .done_o,
    .malformed_o,
    .stream_type_ok_o,
    .pes_id_ok_o,
    .comp_type_applies_o,
    .main_audio_buffer_total_o
);

`default_nettype wire

// File: tb/adp_parser_tb.sv
/*
 * adp_parser_tb: random and corner-case descriptor streams into adp_parser.
 * Assumes adp_pkg, the design, checker and byte source model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module adp_parser_tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic hold_i = 1'b0;
    logic hold_force = 1'b0;
    logic slow = 1'b0;
    logic [7:0] pmt_stream_type_i = 8'h00;
    logic [7:0] pes_stream_number_i = 8'h00;
    logic [7:0] comp_stream_content_i = 8'h00;
    logic [12:0] pid_i = 13'h0000;
    logic [15:0] access_unit_buffer_i = 16'h0000;
    logic in_valid_i;
    adp_pkg::adp_beat_t in_beat_i;
    logic in_ready_o, done_o, malformed_o, stream_type_ok_o, pes_id_ok_o;
    logic comp_type_applies_o, lang_valid_o, idle;
    logic [15:0] main_audio_buffer_total_o;
    logic [23:0] lang_code_o, lc;
    adp_pkg::adp_fields_t fields_o;
    logic [31:0] seed, r;
    int n_errors = 0;
    int comparisons = 0;

    adp_parser #(.FIFO_DEPTH(8)) adp_parser_i (.clk_sys_i, .rst_i, .in_valid_i, .in_beat_i,
        .in_ready_o, .hold_i, .pmt_stream_type_i, .pes_stream_number_i, .pid_i,
        .comp_stream_content_i, .access_unit_buffer_i, .fields_o, .done_o, .malformed_o,
        .stream_type_ok_o, .pes_id_ok_o, .comp_type_applies_o, .main_audio_buffer_total_o,
        .lang_valid_o, .lang_code_o);
    adp_demux_model adp_demux_model_i (.clk_sys_i, .rst_i, .slow_i(slow),
        .ready_i(in_ready_o), .valid_o(in_valid_i), .beat_o(in_beat_i), .idle_o(idle));

    always #20 clk_sys_i = ~clk_sys_i;

    // matches forced half the time so both outcomes of each check occur
    always @(posedge clk_sys_i) begin
        r = $random(seed);
        hold_i <= hold_force | (r[1:0] == 2'h0);
        slow <= r[3:2] == 2'h0;
        pmt_stream_type_i <= r[4] ? 8'h06 : r[15:8];
        pes_stream_number_i <= r[5] ? 8'hBD : r[23:16];
        comp_stream_content_i <= r[6] ? 8'h04 : r[31:24];
    end

    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_sys_i);
            if (done_o === 1'b1) return;
        end
        n_errors++;
        $display("[FAIL] done_o expected 1 seen none");
        results();
    endtask

    // other descriptor, then language descriptor with one spare byte
    task automatic lead_in(output logic [23:0] code);
        code = 24'($random(seed));
        adp_demux_model_i.put(1'b1, 8'h52);
        adp_demux_model_i.put(1'b0, 8'h03);
        for (int i = 0; i < 3; i++) adp_demux_model_i.put(1'b0, 8'h6A);
        adp_demux_model_i.put(1'b0, 8'h0A);
        adp_demux_model_i.put(1'b0, 8'h04);
        for (int i = 2; i >= 0; i--) adp_demux_model_i.put(1'b0, code[i*8 +: 8]);
        adp_demux_model_i.put(1'b0, 8'h55);
    endtask

    // cut below zero sends the full length
    task automatic audio(input logic first, input logic [3:0] fl, input int extra,
        input int cut);
        logic [7:0] v [4];
        logic [7:0] pl [$];
        int pos [4];
        logic [3:0] pr;
        int len, need;
        @(posedge clk_sys_i);
        pid_i <= 13'($random(seed));
        access_unit_buffer_i <= 16'($random(seed)) & 16'h0FFF;
        for (int i = 0; i < 4; i++) v[i] = 8'($random(seed));
        v[2] = v[2] & 8'h0F;
        pl.push_back({fl, 4'($random(seed))});
        for (int i = 0; i < 4; i++) begin
            pos[i] = pl.size();
            if (fl[3 - i]) pl.push_back(v[i]);
        end
        need = pl.size();
        for (int i = 0; i < extra; i++) pl.push_back(8'h6A);
        len = (cut < 0) ? pl.size() : cut;
        for (int i = 0; i < 4; i++) pr[3 - i] = fl[3 - i] && (pos[i] < len);
        adp_demux_model_i.put(first, 8'h6A);
        adp_demux_model_i.put(1'b0, 8'(len));
        for (int i = 0; i < len; i++) adp_demux_model_i.put(1'b0, pl[i]);
        wait_done();
        chk("present", pr, {fields_o.audio_kind_present,
            fields_o.version_present, fields_o.main_present, fields_o.assoc_present});
        chk("malformed_o", len < need, malformed_o);
        chk("pid", pid_i, fields_o.pid);
        if (pr[3]) chk("kind", v[0], fields_o.audio_kind_code);
        if (pr[2]) chk("version", {v[1][4:0], |v[1][7:5], v[1] == 8'h08},
            {fields_o.coding_version, fields_o.version_hi_nonzero,
            fields_o.version_is_current});
        if (pr[1]) chk("main", {v[2][2:0], v[2] > 8'h07},
            {fields_o.main_service, fields_o.main_out_of_range});
        if (pr[0]) chk("mask", v[3], fields_o.assoc_mask);
    endtask

    initial begin
        seed = 32'h8091;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("in_ready_o", 1, in_ready_o);
        chk("buffer", 16'h0E00, main_audio_buffer_total_o);
        audio(1'b1, 4'hF, 0, -1);
        audio(1'b1, 4'h0, 0, -1);
        audio(1'b1, 4'hF, 0, 0);
        audio(1'b1, 4'hF, 0, 3);
        audio(1'b1, 4'h9, 3, -1);
        lead_in(lc);
        audio(1'b0, 4'hF, 1, -1);
        chk("lang", {1'b1, lc}, {lang_valid_o, lang_code_o});
        // abandoned descriptor must not produce done
        adp_demux_model_i.put(1'b1, 8'h6A);
        adp_demux_model_i.put(1'b0, 8'h05);
        adp_demux_model_i.put(1'b0, 8'hF0);
        audio(1'b1, 4'hA, 0, -1);
        // stall the consumer until the fifo refuses
        @(posedge clk_sys_i);
        hold_force <= 1'b1;
        lead_in(lc);
        repeat (40) @(negedge clk_sys_i);
        chk("in_ready_o", 0, in_ready_o);
        chk("withheld", 0, idle);
        @(posedge clk_sys_i);
        hold_force <= 1'b0;
        audio(1'b1, 4'h5, 0, -1);
        for (int k = 0; k < 40; k++) audio(1'b1, 4'($random(seed)), $random(seed) & 3, -1);
        repeat (4) @(negedge clk_sys_i);
        chk("buffer", 16'h0320 + access_unit_buffer_i, main_audio_buffer_total_o);
        results();
    end
endmodule // adp_parser_tb

`default_nettype wire
